// ===== verilog/viterbi_ctrl_defs.vh
`ifndef VITERBI_CTRL_DEFS_VH
`define VITERBI_CTRL_DEFS_VH
`define IC_WORDS        6
`define IC_IDX_W        3
`define IC_LAST         3'h5
`define IC_MASK_ALL     6'h3f
`define CMD_W           4
`define CMD_NONE        4'h0
`define CMD_START       4'h1
`define CMD_PAUSE       4'h2
`define CMD_UNPAUSE     4'h3
`define CMD_STEP        4'h4
`define CMD_RESET       4'h5
`define FMT_BM_BIT      0
`define FMT_SD_BIT      1
`define FMT_W           2
`define FMT_RESET       2'h0
`define FMT_NATIVE_ALL  2'h3
`define FMT_PACKED_ALL  2'h0
`define CNT_W           16
`define CNT_ZERO        16'h0000
`define CNT_ONE         16'h0001
`define WORD_ZERO       32'h0000_0000
`define ST_W            3
`define ST_IDLE         3'h0
`define ST_WAIT_CFG     3'h1
`define ST_RUN          3'h2
`define ST_PAUSING      3'h3
`define ST_PAUSED       3'h4
`define ST_STEP         3'h5
`define ST_FAULT        3'h6
`define STAT_ERR        0
`define STAT_RUN        1
`define STAT_PAUSE      2
`define STAT_IFEMPTY    3
`define STAT_OFFULL     4
`define STAT_WAITCFG    5
`define STAT_W          6
`endif

// ===== verilog/cfg_word_bank.v
`timescale 1ns/1ps
`include "viterbi_ctrl_defs.vh"
module cfg_word_bank (
	input  wire                   clk,
	input  wire                   rstn,
	input  wire                   wr_en,
	input  wire [`IC_IDX_W-1:0]   wr_idx,
	input  wire [31:0]            wr_data,
	input  wire                   clr_seen,
	input  wire [`IC_IDX_W-1:0]   rd_idx,
	output reg  [31:0]            rd_data_q,
	output wire                   all_seen
);
	reg [31:0]          word_q [0:`IC_WORDS-1];
	reg [`IC_WORDS-1:0] seen_q;
	integer             i;

	// Out of range indices are dropped so the bank never aliases
	always @(posedge clk) begin
		if (!rstn) begin
			for (i = 0; i < `IC_WORDS; i = i + 1)
				word_q[i] <= `WORD_ZERO;
			seen_q    <= {`IC_WORDS{1'b0}};
			rd_data_q <= `WORD_ZERO;
		end else begin
			if (wr_en && wr_idx <= `IC_LAST)
				word_q[wr_idx] <= wr_data;
			// A write in the clearing cycle still counts
			if (clr_seen)
				seen_q <= {`IC_WORDS{1'b0}};
			if (wr_en && wr_idx <= `IC_LAST)
				seen_q[wr_idx] <= 1'b1;
			rd_data_q <= (rd_idx <= `IC_LAST) ? word_q[rd_idx]
				: `WORD_ZERO;
		end
	end

	assign all_seen = (seen_q == `IC_MASK_ALL);
endmodule // cfg_word_bank

// ===== verilog/viterbi_engine_ctrl.v
`timescale 1ns/1ps
`include "viterbi_ctrl_defs.vh"
module viterbi_engine_ctrl (
	input  wire                   clk,
	input  wire                   rstn,
	input  wire                   cfg_wr_en,
	input  wire [`IC_IDX_W-1:0]   cfg_wr_idx,
	input  wire [31:0]            cfg_wr_data,
	input  wire [`IC_IDX_W-1:0]   cfg_rd_idx,
	output wire [31:0]            cfg_rd_data,
	input  wire                   fmt_wr_en,
	input  wire [`FMT_W-1:0]      fmt_wr_data,
	output reg                    bm_native_q,
	output reg                    sd_native_q,
	input  wire                   cmd_wr_en,
	input  wire [`CMD_W-1:0]      cmd_wr_data,
	output reg  [`CMD_W-1:0]      exec_command_reg_q,
	input  wire                   debug_mode,
	input  wire                   err_detail_rd,
	input  wire                   engine_error,
	input  wire                   symbol_done,
	input  wire                   traceback_start,
	input  wire                   frame_done,
	input  wire                   in_fifo_empty,
	input  wire                   out_fifo_full,
	output reg                    restart_traceback_q,
	output reg                    engine_go_q,
	output reg                    in_queue_empty_flag_q,
	output reg                    out_queue_full_flag_q,
	output reg  [`STAT_W-1:0]     status_word_zero_q,
	output reg  [`CNT_W-1:0]      symbols_done_count_q
);
	reg [`ST_W-1:0]  state_q;
	reg [`ST_W-1:0]  state_d;
	reg              fault_q;
	reg              clr_seen;
	reg [`CNT_W-1:0] count_d;
	wire             all_seen;
	wire             cmd_start;
	wire             cmd_pause;
	wire             cmd_unpause;
	wire             cmd_step;
	wire             cmd_reset;
	wire             run_d;
	wire             pause_d;
	wire             wait_d;
	wire             fault_d;

	function is_cmd;
		input [`CMD_W-1:0] code;
		begin
			is_cmd = cmd_wr_en && (cmd_wr_data == code);
		end
	endfunction

	assign cmd_start   = is_cmd(`CMD_START);
	// Pause family is ignored outside debug mode as a safety net
	assign cmd_pause   = is_cmd(`CMD_PAUSE) && debug_mode;
	assign cmd_unpause = is_cmd(`CMD_UNPAUSE) && debug_mode;
	assign cmd_step    = is_cmd(`CMD_STEP) && debug_mode;
	assign cmd_reset   = is_cmd(`CMD_RESET);

	cfg_word_bank u_bank (
		.clk       (clk),
		.rstn      (rstn),
		.wr_en     (cfg_wr_en),
		.wr_idx    (cfg_wr_idx),
		.wr_data   (cfg_wr_data),
		.clr_seen  (clr_seen),
		.rd_idx    (cfg_rd_idx),
		.rd_data_q (cfg_rd_data),
		.all_seen  (all_seen)
	);

	always @* begin
		state_d  = state_q;
		clr_seen = 1'b0;
		case (state_q)
		`ST_IDLE: begin
			if (cmd_start) begin
				state_d  = `ST_WAIT_CFG;
				clr_seen = 1'b1;
			end
		end
		`ST_WAIT_CFG: begin
			if (all_seen)
				state_d = `ST_RUN;
		end
		`ST_RUN: begin
			if (frame_done)
				state_d = `ST_IDLE;
			else if (cmd_pause)
				state_d = `ST_PAUSING;
		end
		`ST_PAUSING: begin
			// Halt only lands on a traceback boundary
			if (frame_done)
				state_d = `ST_IDLE;
			else if (traceback_start)
				state_d = `ST_PAUSED;
		end
		`ST_PAUSED: begin
			if (cmd_unpause)
				state_d = `ST_RUN;
			else if (cmd_step)
				state_d = `ST_STEP;
		end
		`ST_STEP: begin
			if (frame_done)
				state_d = `ST_IDLE;
			else if (traceback_start)
				state_d = `ST_PAUSED;
		end
		`ST_FAULT: begin
			if (!fault_q)
				state_d = `ST_IDLE;
		end
		default: state_d = `ST_IDLE;
		endcase
		if (engine_error && state_q != `ST_IDLE)
			state_d = `ST_FAULT;
		if (cmd_reset)
			state_d = `ST_IDLE;
	end

	// Error set beats the read-side clear in the same cycle
	assign fault_d = engine_error ? 1'b1 :
		((err_detail_rd || cmd_reset) ? 1'b0 : fault_q);
	assign run_d   = (state_d == `ST_RUN) || (state_d == `ST_STEP) ||
		(state_d == `ST_PAUSING);
	assign pause_d = (state_d == `ST_PAUSED);
	assign wait_d  = (state_d == `ST_WAIT_CFG);

	always @* begin
		count_d = symbols_done_count_q;
		if (cmd_reset || (state_q == `ST_IDLE && cmd_start))
			count_d = `CNT_ZERO;
		else if (symbol_done && (state_q == `ST_RUN ||
			state_q == `ST_STEP || state_q == `ST_PAUSING))
			count_d = symbols_done_count_q + `CNT_ONE;
	end

	always @(posedge clk) begin
		if (!rstn) begin
			state_q               <= `ST_IDLE;
			fault_q               <= 1'b0;
			bm_native_q           <= 1'b0;
			sd_native_q           <= 1'b0;
			exec_command_reg_q    <= `CMD_NONE;
			restart_traceback_q   <= 1'b0;
			engine_go_q           <= 1'b0;
			in_queue_empty_flag_q <= 1'b1;
			out_queue_full_flag_q <= 1'b0;
			status_word_zero_q    <= {`STAT_W{1'b0}};
			symbols_done_count_q  <= `CNT_ZERO;
		end else begin
			state_q <= state_d;
			fault_q <= fault_d;
			// Format is kept across the reset command
			if (fmt_wr_en) begin
				bm_native_q <= fmt_wr_data[`FMT_BM_BIT];
				sd_native_q <= fmt_wr_data[`FMT_SD_BIT];
			end
			if (cmd_wr_en)
				exec_command_reg_q <= cmd_wr_data;
			restart_traceback_q <= (state_q == `ST_PAUSED) &&
				(cmd_unpause || cmd_step);
			engine_go_q <= run_d;
			in_queue_empty_flag_q <= in_fifo_empty;
			out_queue_full_flag_q <= out_fifo_full;
			status_word_zero_q[`STAT_ERR]     <= fault_d;
			status_word_zero_q[`STAT_RUN]     <= run_d;
			status_word_zero_q[`STAT_PAUSE]   <= pause_d;
			status_word_zero_q[`STAT_IFEMPTY] <= in_fifo_empty;
			status_word_zero_q[`STAT_OFFULL]  <= out_fifo_full;
			status_word_zero_q[`STAT_WAITCFG] <= wait_d;
			symbols_done_count_q <= count_d;
		end
	end
endmodule // viterbi_engine_ctrl

// ===== dv/viterbi_monitor.sv
`timescale 1ns/1ps
`include "viterbi_ctrl_defs.vh"
module viterbi_monitor (
	input wire               clk,
	input wire               rstn,
	input wire               fmt_wr_en,
	input wire [`FMT_W-1:0]  fmt_wr_data,
	input wire               bm_native_q,
	input wire               sd_native_q,
	input wire               cmd_wr_en,
	input wire [`CMD_W-1:0]  cmd_wr_data,
	input wire               engine_error,
	input wire               err_detail_rd,
	input wire               symbol_done,
	input wire               traceback_start,
	input wire               frame_done,
	input wire               in_fifo_empty,
	input wire               in_queue_empty_flag_q,
	input wire [`STAT_W-1:0] status_word_zero_q,
	input wire [`CNT_W-1:0]  symbols_done_count_q
);
	wire [`STAT_W-1:0] st = status_word_zero_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Idle means no error, run, pause or wait bit
	sequence s_start;
		cmd_wr_en && cmd_wr_data == `CMD_START && (st & 6'h27) == 6'h00;
	endsequence
	a_start_wait: assert property (s_start |=> st[`STAT_WAITCFG])
		else $error("start did not raise wait flag");
	a_fmt_bm: assert property (fmt_wr_en |=>
		bm_native_q == $past(fmt_wr_data[`FMT_BM_BIT]))
		else $error("branch format bit wrong");
	a_fmt_sd: assert property (fmt_wr_en |=>
		sd_native_q == $past(fmt_wr_data[`FMT_SD_BIT]))
		else $error("soft format bit wrong");
	a_in_empty: assert property ($past(rstn) |->
		in_queue_empty_flag_q == $past(in_fifo_empty) &&
		st[`STAT_IFEMPTY] == $past(in_fifo_empty))
		else $error("input empty flag wrong");
	a_err_set: assert property (engine_error && !cmd_wr_en |=>
		st[`STAT_ERR]) else $error("error not flagged");
	a_err_clr: assert property (err_detail_rd && !engine_error &&
		!cmd_wr_en |=> !st[`STAT_ERR]) else $error("fault not cleared");
	a_pause_tb: assert property ($rose(st[`STAT_PAUSE]) |->
		$past(traceback_start)) else $error("pause off boundary");
	a_sym_cnt: assert property (symbol_done && st[`STAT_RUN] &&
		!frame_done && !cmd_wr_en && !engine_error |=>
		symbols_done_count_q == $past(symbols_done_count_q) + `CNT_ONE)
		else $error("symbol count wrong");
endmodule // viterbi_monitor

// ===== dv/host_cfg_model.sv
`timescale 1ns/1ps
module host_cfg_model (
	input  wire        clk,
	input  wire        load,
	output reg         cfg_wr_en,
	output reg  [2:0]  cfg_wr_idx,
	output reg  [31:0] cfg_wr_data
);
	reg [2:0] n = 3'h6;
	initial cfg_wr_en = 1'h0;
	initial cfg_wr_idx = 3'h0;
	initial cfg_wr_data = 32'h0000_0000;
	// Idle bus toggles so a stale word never looks fresh
	always @(negedge clk) begin
		n = load ? 3'h0 : (n < 3'h6 ? n + 3'h1 : n);
		cfg_wr_en <= n < 3'h6;
		cfg_wr_idx <= n < 3'h6 ? n : ~cfg_wr_idx;
		cfg_wr_data <= n < 3'h6 ? 32'hA5A5_0000 | n : ~cfg_wr_data;
	end
endmodule // host_cfg_model

// ===== dv/viterbi_engine_ctrl_bench.sv
`timescale 1ns/1ps
`include "viterbi_ctrl_defs.vh"
bind viterbi_engine_ctrl viterbi_monitor mon (.*);
module viterbi_engine_ctrl_bench;
	logic clk = 1'h0, rstn = 1'h0, load = 1'h0, debug_mode = 1'h0;
	logic fmt_wr_en = 1'h0, cmd_wr_en = 1'h0, symbol_done = 1'h0;
	logic engine_error = 1'h0, err_detail_rd = 1'h0, frame_done = 1'h0;
	logic traceback_start = 1'h0, in_fifo_empty = 1'h1;
	logic out_fifo_full = 1'h0;
	logic [1:0] fmt_wr_data = 2'h0;
	logic [3:0] cmd_wr_data = 4'h0;
	logic [2:0] cfg_rd_idx = 3'h0;
	wire cfg_wr_en, bm_native_q, sd_native_q, restart_traceback_q;
	wire engine_go_q, in_queue_empty_flag_q, out_queue_full_flag_q;
	wire [2:0] cfg_wr_idx;
	wire [31:0] cfg_wr_data, cfg_rd_data;
	wire [3:0] exec_command_reg_q;
	wire [5:0] status_word_zero_q;
	wire [15:0] symbols_done_count_q;
	integer error_cnt = 0, checked = 0;
	viterbi_engine_ctrl dut (.*);
	host_cfg_model host (.clk(clk), .load(load), .cfg_wr_en(cfg_wr_en),
		.cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data));
	always #20 clk = ~clk;
	task chk(input string n, input [31:0] s, input [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s exp %h seen %h", n, e, s);
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task cmd(input [3:0] c);
		cmd_wr_data = c;
		cmd_wr_en = 1'h1;
		cyc(1);
		cmd_wr_en = 1'h0;
	endtask
	// Only the strobes raised here are touched, so back to back calls
	// with different strobes never drive one signal twice in a time step
	task tick(input [4:0] m);
		if (m[4])
			engine_error = 1'h1;
		if (m[3])
			err_detail_rd = 1'h1;
		if (m[2])
			traceback_start = 1'h1;
		if (m[1])
			frame_done = 1'h1;
		cyc(1);
		if (m[4])
			engine_error = 1'h0;
		if (m[3])
			err_detail_rd = 1'h0;
		if (m[2])
			traceback_start = 1'h0;
		if (m[1])
			frame_done = 1'h0;
	endtask
	task t_flags;
		for (int i = 0; i < 4; i++) begin
			{out_fifo_full, in_fifo_empty} = 2'(i);
			cyc(1);
			chk("ie", in_queue_empty_flag_q, i & 1);
			chk("of", out_queue_full_flag_q, i >> 1);
			chk("st", status_word_zero_q, i << 3);
		end
		{out_fifo_full, in_fifo_empty} = 2'h0;
		cyc(1);
		$display("flags done");
	endtask
	task t_fmt;
		fmt_wr_en = 1'h1;
		for (int i = 0; i < 4; i++) begin
			fmt_wr_data = 2'(i);
			cyc(1);
			chk("bm", bm_native_q, i & 1);
			chk("sd", sd_native_q, i >> 1);
		end
		fmt_wr_en = 1'h0;
		$display("format done");
	endtask
	task t_frame;
		load <= 1'h1;
		cmd(`CMD_START);
		load <= 1'h0;
		chk("wait", status_word_zero_q, 6'h20);
		// Last word lands one edge before the run status bit rises
		cyc(7);
		chk("run", status_word_zero_q, 6'h02);
		chk("go", engine_go_q, 1);
		symbol_done = 1'h1;
		cyc(3);
		symbol_done = 1'h0;
		chk("cnt", symbols_done_count_q, 3);
		for (int i = 0; i < 7; i++) begin
			cfg_rd_idx = 3'(i);
			cyc(1);
			chk("cfg", cfg_rd_data, i < 6 ? 32'hA5A5_0000 | i : 0);
		end
		cmd(`CMD_PAUSE);
		tick(5'h04);
		chk("nodbg", status_word_zero_q, 6'h02);
		debug_mode = 1'h1;
		cmd(`CMD_PAUSE);
		tick(5'h04);
		chk("pause", status_word_zero_q, 6'h04);
		chk("halt", engine_go_q, 0);
		cmd(`CMD_STEP);
		chk("rs", restart_traceback_q, 1);
		tick(5'h04);
		chk("step", status_word_zero_q, 6'h04);
		cmd(`CMD_UNPAUSE);
		chk("rs", restart_traceback_q, 1);
		chk("run", status_word_zero_q, 6'h02);
		chk("exe", exec_command_reg_q, `CMD_UNPAUSE);
		tick(5'h02);
		chk("end", status_word_zero_q, 6'h00);
		$display("frame done");
	endtask
	task t_fault;
		cfg_rd_idx = 3'h0;
		tick(5'h10);
		chk("err", status_word_zero_q, 6'h01);
		tick(5'h08);
		chk("clr", status_word_zero_q, 6'h00);
		tick(5'h10);
		cmd(`CMD_RESET);
		chk("rcmd", status_word_zero_q, 6'h00);
		chk("cnt", symbols_done_count_q, 0);
		chk("fmt", {sd_native_q, bm_native_q}, `FMT_NATIVE_ALL);
		chk("keep", cfg_rd_data, 32'hA5A5_0000);
		$display("fault done");
	endtask
	task stop_test;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		cyc(12);
		rstn = 1'h1;
		cyc(1);
		chk("ie0", in_queue_empty_flag_q, 1);
		t_flags;
		t_fmt;
		t_frame;
		t_fault;
		stop_test;
	end
	// Whole run is about 52 cycles; far margin here
	initial begin
		#100000;
		error_cnt++;
		stop_test;
	end
endmodule // viterbi_engine_ctrl_bench
